// ### exec_core.sv
// How it works
// - Load-literal puts the 8-bit immediate in the accumulator, no flag changes.
// - Configuration-load copies the accumulator into the configuration register.
// - Return-with-literal puts the immediate in the accumulator, flags untouched.
// - Return-with-literal reloads the instruction pointer from the stack top.
// - Return-with-literal takes two cycles; the prefetched word is discarded.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep sets the watchdog-expiry flag to one.
// - Sleep clears the powerdown flag, pin-change wake flag untouched.
// - After sleep the oscillator halts and execution stops.
// - Subtract computes file value minus accumulator in two's complement.
// - Destination bit zero writes the accumulator, one writes the file register.
`timescale 1ns/1ps

module exec_core (
  input  wire logic        clock,        // 100 MHz core clock
  input  wire logic        rst_b,        // Asynchronous reset, active low
  input  wire logic [11:0] instr,        // Fetched instruction word
  input  wire logic        instr_valid,  // Instruction word present
  output logic             instr_taken,  // Pulse: word consumed this cycle
  input  wire logic [10:0] stack_top,    // Top of the return-address stack
  output logic      [10:0] ip,           // Instruction pointer
  output logic             osc_run,      // High while the oscillator runs
  output logic      [7:0]  acc_out,      // Accumulator contents
  output logic      [7:0]  config_out,   // Configuration register contents
  input  wire logic [5:0]  addr,         // Register port address
  input  wire logic [7:0]  wdata,        // Register port write data
  input  wire logic        wr,           // Write strobe
  input  wire logic        rd,           // Read strobe
  output logic      [7:0]  rdata         // Read data, one cycle after rd
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    RUN   = 3'b001,
    FLUSH = 3'b010,
    SLEEP = 3'b100
  } mode_t;

  typedef struct packed {
    mode_t             mode;
    logic [1:0]        phase;
    logic [7:0]        acc;
    logic [7:0]        cfg;
    logic [31:0][7:0]  file;
    logic              carry;
    logic              nibble;
    logic              zero;
    logic              expiry;
    logic              powerdown;
    logic              wake;
    logic [7:0]        wdog;
    logic [7:0]        wpre;
    logic [10:0]       ip;
    logic              taken;
    logic [7:0]        rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  alu_if alu_bus ();

  exec_alu u_alu (
    .bus (alu_bus)
  );

  // ------------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------------
  function automatic logic is_lit(input logic [11:0] w, input logic [11:0] op);
    is_lit = ((w & exec_pkg::LIT_MASK) == op);
  endfunction : is_lit

  function automatic logic is_file(input logic [11:0] w, input logic [11:0] op);
    is_file = ((w & exec_pkg::FILE_MASK) == op);
  endfunction : is_file

  function automatic logic [7:0] status_byte(input state_t s);
    status_byte = 8'h00;
    status_byte[exec_pkg::ST_CARRY] = s.carry;
    status_byte[exec_pkg::ST_NIBBLE] = s.nibble;
    status_byte[exec_pkg::ST_ZERO] = s.zero;
    status_byte[exec_pkg::ST_POWERDOWN] = s.powerdown;
    status_byte[exec_pkg::ST_EXPIRY] = s.expiry;
    status_byte[exec_pkg::ST_WAKE] = s.wake;
  endfunction : status_byte

  // ------------------------------------------------------------------
  // Combinational decode signals
  // ------------------------------------------------------------------
  logic       tick;
  logic       exec_ok;
  logic [4:0] faddr;
  logic       dest_file;
  logic [7:0] fval;
  logic       op_load;
  logic       op_ret;
  logic       op_cfg;
  logic       op_sleep;
  logic       op_rot;
  logic       op_sub;

  // The instruction cycle only advances while the oscillator runs
  assign tick = (state_reg.phase == exec_pkg::CYCLE_LAST);
  assign exec_ok = tick && instr_valid && (state_reg.mode == RUN);
  assign faddr = instr[4:0];
  assign dest_file = instr[exec_pkg::DEST_BIT];
  assign fval = state_reg.file[faddr];
  assign op_load = is_lit(instr, exec_pkg::LOAD_LITERAL_OP);
  assign op_ret = is_lit(instr, exec_pkg::RETURN_WITH_LITERAL_OP);
  assign op_cfg = (instr == exec_pkg::CONFIG_LOAD_OP);
  assign op_sleep = (instr == exec_pkg::SLEEP_OP);
  assign op_rot = is_file(instr, exec_pkg::ROTATE_LEFT_CARRY_OP);
  assign op_sub = is_file(instr, exec_pkg::SUBTRACT_FROM_FILE_OP);

  assign alu_bus.subtract = op_sub;
  assign alu_bus.fval = fval;
  assign alu_bus.acc = state_reg.acc;
  assign alu_bus.cin = state_reg.carry;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.taken = 1'b0;
    state_next.rdata = 8'h00;

    // Divider: the phase counter stops with the oscillator
    if (state_reg.mode != SLEEP) begin
      if (tick) begin
        state_next.phase = 2'h0;
      end else begin
        state_next.phase = state_reg.phase + 2'h1;
      end
    end

    // Watchdog keeps its own count, even while the core sleeps
    if (tick || state_reg.mode == SLEEP) begin
      state_next.wpre = state_reg.wpre + 8'h01;
      if (state_reg.wpre == 8'hff) begin
        state_next.wdog = state_reg.wdog + 8'h01;
        if (state_reg.wdog == 8'hff) begin
          state_next.expiry = 1'b0;
        end
      end
    end

    // Register port writes come first, so hardware events below win
    if (wr) begin
      if (addr <= exec_pkg::ADDR_FILE_TOP) begin
        state_next.file[addr[4:0]] = wdata;
      end else begin
        unique case (addr)
          exec_pkg::ADDR_ACC: begin
            state_next.acc = wdata;
          end
          exec_pkg::ADDR_CONFIG: begin
            state_next.cfg = wdata;
          end
          exec_pkg::ADDR_STATUS: begin
            state_next.carry = wdata[exec_pkg::ST_CARRY];
            state_next.nibble = wdata[exec_pkg::ST_NIBBLE];
            state_next.zero = wdata[exec_pkg::ST_ZERO];
            state_next.powerdown = wdata[exec_pkg::ST_POWERDOWN];
            state_next.expiry = wdata[exec_pkg::ST_EXPIRY];
            state_next.wake = wdata[exec_pkg::ST_WAKE];
          end
          exec_pkg::ADDR_WATCHDOG: begin
            state_next.wdog = 8'h00;
            state_next.wpre = 8'h00;
          end
          exec_pkg::ADDR_CONTROL: begin
            // Writing a one to the asleep bit restarts the oscillator
            if (wdata[exec_pkg::CT_ASLEEP] && state_reg.mode == SLEEP) begin
              state_next.mode = RUN;
              state_next.phase = 2'h0;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Register port reads
    if (rd) begin
      if (addr <= exec_pkg::ADDR_FILE_TOP) begin
        state_next.rdata = state_reg.file[addr[4:0]];
      end else begin
        unique case (addr)
          exec_pkg::ADDR_ACC: begin
            state_next.rdata = state_reg.acc;
          end
          exec_pkg::ADDR_CONFIG: begin
            state_next.rdata = state_reg.cfg;
          end
          exec_pkg::ADDR_STATUS: begin
            state_next.rdata = status_byte(state_reg);
          end
          exec_pkg::ADDR_WATCHDOG: begin
            state_next.rdata = state_reg.wdog;
          end
          exec_pkg::ADDR_CONTROL: begin
            state_next.rdata[exec_pkg::CT_ASLEEP] = (state_reg.mode == SLEEP);
            state_next.rdata[exec_pkg::CT_FLUSH] = (state_reg.mode == FLUSH);
          end
          default: begin
            state_next.rdata = 8'h00;
          end
        endcase
      end
    end

    // Second cycle of a return: the prefetched word is thrown away
    if (tick && state_reg.mode == FLUSH) begin
      state_next.mode = RUN;
      state_next.taken = instr_valid;
    end

    // Instruction execution, one instruction cycle each, two for a return
    if (exec_ok) begin
      state_next.taken = 1'b1;
      state_next.ip = state_reg.ip + 11'h001;
      if (op_load) begin
        state_next.acc = instr[7:0];
      end else if (op_ret) begin
        state_next.acc = instr[7:0];
        state_next.ip = stack_top;
        state_next.mode = FLUSH;
      end else if (op_cfg) begin
        state_next.cfg = state_reg.acc;
      end else if (op_sleep) begin
        state_next.wdog = 8'h00;
        state_next.wpre = 8'h00;
        state_next.expiry = 1'b1;
        state_next.powerdown = 1'b0;
        state_next.mode = SLEEP;
        state_next.phase = 2'h0;
      end else if (op_rot || op_sub) begin
        if (dest_file) begin
          state_next.file[faddr] = alu_bus.res;
        end else begin
          state_next.acc = alu_bus.res;
        end
        state_next.carry = alu_bus.cout;
        if (op_sub) begin
          state_next.nibble = alu_bus.dcout;
          state_next.zero = alu_bus.zout;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
      state_reg.mode <= RUN;
      state_reg.cfg <= exec_pkg::CONFIG_RESET;
      state_reg.ip <= exec_pkg::IP_RESET;
      state_reg.expiry <= 1'b1;
      state_reg.powerdown <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign instr_taken = state_reg.taken;
  assign ip = state_reg.ip;
  assign osc_run = (state_reg.mode != SLEEP);
  assign acc_out = state_reg.acc;
  assign config_out = state_reg.cfg;
  assign rdata = state_reg.rdata;

endmodule : exec_core

// ### exec_pkg.sv
package exec_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned INSTR_CYCLE_NS = 40;
  localparam int unsigned CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] CYCLE_LAST = 2'(CYCLE_CLKS - 1);

  // ------------------------------------------------------------------
  // Instruction encodings (12-bit words)
  // ------------------------------------------------------------------
  localparam logic [11:0] LIT_MASK = 12'hf00;
  localparam logic [11:0] LOAD_LITERAL_OP = 12'hc00;
  localparam logic [11:0] RETURN_WITH_LITERAL_OP = 12'h800;
  localparam logic [11:0] FILE_MASK = 12'hfc0;
  localparam logic [11:0] ROTATE_LEFT_CARRY_OP = 12'h340;
  localparam logic [11:0] SUBTRACT_FROM_FILE_OP = 12'h080;
  localparam logic [11:0] CONFIG_LOAD_OP = 12'h002;
  localparam logic [11:0] SLEEP_OP = 12'h003;
  localparam int unsigned DEST_BIT = 5;

  // ------------------------------------------------------------------
  // Register port map
  // ------------------------------------------------------------------
  localparam logic [5:0] ADDR_FILE_TOP = 6'h1f;
  localparam logic [5:0] ADDR_ACC = 6'h20;
  localparam logic [5:0] ADDR_CONFIG = 6'h21;
  localparam logic [5:0] ADDR_STATUS = 6'h22;
  localparam logic [5:0] ADDR_WATCHDOG = 6'h23;
  localparam logic [5:0] ADDR_CONTROL = 6'h24;

  // Status bit positions
  localparam int unsigned ST_CARRY = 0;
  localparam int unsigned ST_NIBBLE = 1;
  localparam int unsigned ST_ZERO = 2;
  localparam int unsigned ST_POWERDOWN = 3;
  localparam int unsigned ST_EXPIRY = 4;
  localparam int unsigned ST_WAKE = 5;
  // Control bit positions
  localparam int unsigned CT_ASLEEP = 0;
  localparam int unsigned CT_FLUSH = 1;

  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'hff;
  localparam logic [10:0] IP_RESET = 11'h7ff;

endpackage : exec_pkg

// ### alu_if.sv
`timescale 1ns/1ps

interface alu_if;
  logic       subtract;
  logic [7:0] fval;
  logic [7:0] acc;
  logic       cin;
  logic [7:0] res;
  logic       cout;
  logic       dcout;
  logic       zout;

  modport core (output subtract, fval, acc, cin, input res, cout, dcout, zout);
  modport alu  (input subtract, fval, acc, cin, output res, cout, dcout, zout);
endinterface : alu_if

// ### exec_alu.sv
`timescale 1ns/1ps

module exec_alu (
  alu_if.alu bus  // Operands in, result and flags out
);

  logic [8:0] diff;
  logic [4:0] low_diff;

  // ------------------------------------------------------------------
  // Rotate or subtract
  // ------------------------------------------------------------------
  always_comb begin
    diff = {1'b0, bus.fval} - {1'b0, bus.acc};
    low_diff = {1'b0, bus.fval[3:0]} - {1'b0, bus.acc[3:0]};
    if (bus.subtract) begin
      bus.res = diff[7:0];
      bus.cout = ~diff[8];
      bus.dcout = ~low_diff[4];
    end else begin
      bus.res = {bus.fval[6:0], bus.cin};
      bus.cout = bus.fval[7];
      bus.dcout = 1'b0;
    end
    bus.zout = (bus.res == 8'h00);
  end

endmodule : exec_alu

// ### exec_core_checker.sv
`timescale 1ns/1ps

module exec_core_checker (
  input logic        clock,       // Core clock
  input logic        rst_b,       // Reset, active low
  input logic [11:0] instr,       // Word offered
  input logic        instr_taken, // Word consumed
  input logic [10:0] stack_top,   // Return address
  input logic [10:0] ip,          // Instruction pointer
  input logic        osc_run,     // Oscillator running
  input logic [7:0]  acc_out,     // Accumulator
  input logic [7:0]  config_out   // Configuration
);
  // --------------------------------------------------------------
  // Executed word tracking
  // --------------------------------------------------------------
  logic [11:0] word_reg;
  logic        skip_reg;
  logic        is_ret;
  logic        ex;
  assign is_ret = (word_reg & exec_pkg::LIT_MASK) == exec_pkg::RETURN_WITH_LITERAL_OP;
  // The slot after a return is consumed but must have no effect
  assign ex = instr_taken && !skip_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      word_reg <= 12'h000;
      skip_reg <= 1'b0;
    end else begin
      word_reg <= instr;
      if (instr_taken) skip_reg <= is_ret && !skip_reg;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_literal_load: assert property (
    ex && (word_reg & exec_pkg::LIT_MASK) == exec_pkg::LOAD_LITERAL_OP
    |-> acc_out == word_reg[7:0]) else $error("literal not in accumulator");
  a_ip_step: assert property (
    ex && (word_reg & exec_pkg::LIT_MASK) == exec_pkg::LOAD_LITERAL_OP
    |-> ip == $past(ip) + 11'h001) else $error("pointer did not step");
  a_config_copy: assert property (
    ex && word_reg == exec_pkg::CONFIG_LOAD_OP |-> config_out == $past(acc_out))
    else $error("configuration not copied");
  a_return_value: assert property (
    ex && is_ret |-> acc_out == word_reg[7:0] && ip == $past(stack_top))
    else $error("return value or pointer wrong");
  a_return_skip: assert property (
    instr_taken && skip_reg |-> $stable(acc_out) && $stable(ip))
    else $error("word after return had an effect");
  a_sleep_halts: assert property (
    ex && word_reg == exec_pkg::SLEEP_OP |-> !osc_run ##1 (!osc_run && !instr_taken))
    else $error("sleep did not halt");
  a_quiet_sleep: assert property (
    !osc_run && !$past(osc_run) |-> !instr_taken && $stable(ip))
    else $error("execution while asleep");
  a_taken_gap: assert property (
    instr_taken |=> !instr_taken [*3]) else $error("instructions closer than one cycle");

  c_return: cover property (ex && is_ret);
  c_skip: cover property (instr_taken && skip_reg);
  c_sleep: cover property (ex && word_reg == exec_pkg::SLEEP_OP);
endmodule : exec_core_checker

// ### literal_sleep_rotate_subtract_exec_tb.sv
`timescale 1ns/1ps

module literal_sleep_rotate_subtract_exec_tb;
  localparam logic [11:0] LDL = exec_pkg::LOAD_LITERAL_OP;
  localparam logic [11:0] SUB = exec_pkg::SUBTRACT_FROM_FILE_OP;
  localparam logic [11:0] ROT = exec_pkg::ROTATE_LEFT_CARRY_OP;
  localparam logic [5:0]  ST  = exec_pkg::ADDR_STATUS;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        instr_valid = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [10:0] stack_top = 11'h000;
  logic [5:0]  addr = 6'h00;
  logic [7:0]  wdata = 8'h00;
  logic        instr_taken;
  logic        osc_run;
  logic [10:0] ip;
  logic [10:0] ip_pre;
  logic [7:0]  acc_out;
  logic [7:0]  config_out;
  logic [7:0]  rdata;
  int          mismatches = 0;
  int          tests_run = 0;

  always #5 clock = ~clock;

  exec_core dut_u (.clock(clock), .rst_b(rst_b), .instr(instr), .instr_valid(instr_valid),
    .instr_taken(instr_taken), .stack_top(stack_top), .ip(ip), .osc_run(osc_run),
    .acc_out(acc_out), .config_out(config_out), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe, so look mid-cycle
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    chk($sformatf("register %h", a), 11'(e), 11'(rdata));
    @(posedge clock);
  endtask : rd_chk

  task automatic wait_taken;
    int n;
    n = 0;
    // The pulse is looked at mid-cycle, away from the edge that launches it
    do begin
      @(negedge clock);
      n++;
    end while (instr_taken !== 1'b1 && n < 8);
    if (instr_taken !== 1'b1) begin
      mismatches++;
      $display("unexpected instr_taken: expected 1 seen %b", instr_taken);
      results();
    end
    @(posedge clock);
  endtask : wait_taken

  // Phase is hidden, so a word is offered just after a consumed slot
  task automatic exec(input logic [11:0] w, input logic [11:0] nxt = 12'h000);
    wait_taken();
    ip_pre = ip;
    instr <= w;
    wait_taken();
    instr <= nxt;
  endtask : exec

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    chk("ip", exec_pkg::IP_RESET, ip);
    chk("osc_run", 11'h001, 11'(osc_run));
    rd_chk(exec_pkg::ADDR_ACC, 8'h00);
    rd_chk(exec_pkg::ADDR_CONFIG, exec_pkg::CONFIG_RESET);
    rd_chk(ST, 8'h18);
    wr_reg(6'h3f, 8'h5a);
    rd_chk(6'h3f, 8'h00);
    $display("reset test done");
  endtask : t_reset

  task automatic t_literal_config;
    exec(LDL | 12'h0ff);
    chk("acc", 11'h0ff, 11'(acc_out));
    chk("ip", ip_pre + 11'h001, ip);
    exec(LDL | 12'h03c);
    exec(exec_pkg::CONFIG_LOAD_OP);
    chk("config", 11'h03c, 11'(config_out));
    rd_chk(ST, 8'h18);
    $display("literal and configuration test done");
  endtask : t_literal_config

  task automatic t_subtract;
    wr_reg(6'h05, 8'h12);
    exec(LDL | 12'h021);
    exec(SUB | 12'h005);
    chk("acc", 11'h0f1, 11'(acc_out));
    rd_chk(6'h05, 8'h12);
    rd_chk(ST, 8'h1a);
    wr_reg(6'h1f, 8'h22);
    exec(LDL | 12'h022);
    exec(SUB | 12'h03f);
    rd_chk(6'h1f, 8'h00);
    chk("acc", 11'h022, 11'(acc_out));
    rd_chk(ST, 8'h1f);
    $display("subtract test done");
  endtask : t_subtract

  task automatic t_rotate;
    wr_reg(6'h03, 8'h81);
    exec(ROT | 12'h023);
    rd_chk(6'h03, 8'h03);
    rd_chk(ST, 8'h1f);
    exec(ROT | 12'h003);
    chk("acc", 11'h007, 11'(acc_out));
    rd_chk(ST, 8'h1e);
    $display("rotate test done");
  endtask : t_rotate

  task automatic t_return;
    stack_top <= 11'h123;
    exec(exec_pkg::RETURN_WITH_LITERAL_OP | 12'h05a, LDL | 12'h077);
    chk("acc", 11'h05a, 11'(acc_out));
    chk("ip", 11'h123, ip);
    wait_taken();
    chk("acc", 11'h05a, 11'(acc_out));
    chk("ip", 11'h123, ip);
    wait_taken();
    chk("acc", 11'h077, 11'(acc_out));
    chk("ip", 11'h124, ip);
    instr <= 12'h000;
    rd_chk(ST, 8'h1e);
    $display("return test done");
  endtask : t_return

  // The long idle lets the watchdog count move off zero first
  task automatic t_sleep;
    repeat (1100) @(posedge clock);
    exec(exec_pkg::SLEEP_OP);
    chk("osc_run", 11'h000, 11'(osc_run));
    ip_pre = ip;
    repeat (8) @(posedge clock);
    chk("ip", ip_pre, ip);
    rd_chk(exec_pkg::ADDR_WATCHDOG, 8'h00);
    rd_chk(ST, 8'h16);
    wr_reg(exec_pkg::ADDR_CONTROL, 8'h01);
    @(posedge clock);
    chk("osc_run", 11'h001, 11'(osc_run));
    exec(LDL | 12'h0a5);
    chk("acc", 11'h0a5, 11'(acc_out));
    $display("sleep test done");
  endtask : t_sleep

  initial begin
    repeat (4) @(posedge clock);
    rst_b       <= 1'b1;
    instr_valid <= 1'b1;
    t_reset();
    t_literal_config();
    t_subtract();
    t_rotate();
    t_return();
    t_sleep();
    results();
  end
endmodule : literal_sleep_rotate_subtract_exec_tb

bind exec_core exec_core_checker chk_u (.clock(clock), .rst_b(rst_b), .instr(instr),
  .instr_taken(instr_taken), .stack_top(stack_top), .ip(ip), .osc_run(osc_run),
  .acc_out(acc_out), .config_out(config_out));
